// ===== sbs_pkg.sv
/*
 * sbs_pkg: register map, field layout, reset values and lock-owner codes
 * for the buffer semaphore block.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package sbs_pkg;

    localparam logic [11:0] SBS_ADDR_TASK_ACQUIRE = 12'h024;
    localparam logic [11:0] SBS_ADDR_TASK_RELEASE = 12'h028;
    localparam logic [11:0] SBS_ADDR_EVT_END      = 12'h104;
    localparam logic [11:0] SBS_ADDR_EVT_RXFULL   = 12'h110;
    localparam logic [11:0] SBS_ADDR_EVT_GRANTED  = 12'h128;
    localparam logic [11:0] SBS_ADDR_SHORTCUT     = 12'h200;
    localparam logic [11:0] SBS_ADDR_IRQ_SET      = 12'h304;
    localparam logic [11:0] SBS_ADDR_IRQ_CLR      = 12'h308;
    localparam logic [11:0] SBS_ADDR_OWNER        = 12'h400;

    // register bit positions: interrupt enables, shortcut, task and event
    localparam int SBS_BIT_END     = 1;
    localparam int SBS_BIT_RXFULL  = 4;
    localparam int SBS_BIT_GRANTED = 10;
    localparam int SBS_BIT_SHORT   = 0;
    localparam int SBS_BIT_TASK    = 0;
    localparam int SBS_BIT_EVT     = 0;

    localparam logic [2:0]  SBS_IRQ_EN_RESET   = 3'h0;
    localparam logic [31:0] SBS_ZERO_WORD      = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        SBS_OWN_FREE    = 2'b00,
        SBS_OWN_CPU     = 2'b01,
        SBS_OWN_SPI     = 2'b10,
        SBS_OWN_SPI_PND = 2'b11
    } sbs_owner_t;

    localparam sbs_owner_t SBS_OWNER_RESET = SBS_OWN_CPU;

endpackage : sbs_pkg

// ===== sbs_lock_fsm.sv
/*
 * sbs_lock_fsm: lock ownership state machine between processor and the
 * serial target engine.
 * Assumes single-cycle task and request pulses on pclk.
 */
`timescale 1ns/1ps
module sbs_lock_fsm
    import sbs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       cpu_acquire,
    input  wire logic       cpu_release,
    input  wire logic       spi_request,
    input  wire logic       spi_done,
    output sbs_owner_t      owner,
    output logic            granted
);

    typedef struct packed
    {
        sbs_owner_t owner;
        logic       granted;
    } sbs_fsm_state_t;

    sbs_fsm_state_t cur;
    sbs_fsm_state_t next_cur;

    always_comb
    begin
        next_cur         = cur;
        next_cur.granted = 1'b0;
        case (cur.owner)
            SBS_OWN_FREE:
            begin
                // processor wins a same-cycle tie
                if (cpu_acquire)
                begin
                    next_cur.owner   = SBS_OWN_CPU;
                    next_cur.granted = 1'b1;
                end
                else if (spi_request)
                    next_cur.owner = SBS_OWN_SPI;
            end
            SBS_OWN_CPU:
            begin
                if (cpu_release)
                    next_cur.owner = SBS_OWN_FREE;
            end
            SBS_OWN_SPI:
            begin
                if (spi_done)
                    next_cur.owner = SBS_OWN_FREE;
                if (cpu_acquire)
                    next_cur.owner = spi_done ? SBS_OWN_CPU
                                              : SBS_OWN_SPI_PND;
                next_cur.granted = cpu_acquire && spi_done;
            end
            SBS_OWN_SPI_PND:
            begin
                if (spi_done)
                begin
                    next_cur.owner   = SBS_OWN_CPU;
                    next_cur.granted = 1'b1;
                end
            end
            default:
                next_cur.owner = SBS_OWN_FREE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur.owner   <= SBS_OWNER_RESET;
            cur.granted <= 1'b0;
        end
        else
            cur <= next_cur;
    end

    assign owner   = cur.owner;
    assign granted = cur.granted;

endmodule : sbs_lock_fsm

// ===== sbs_irq_enable.sv
/*
 * sbs_irq_enable: per-event interrupt enable bits with set and clear
 * write ports, one generate loop over the events.
 * Assumes set and clear strobes are one-cycle pulses.
 */
`timescale 1ns/1ps
module sbs_irq_enable
    import sbs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] set_bits,
    input  wire logic [2:0] clr_bits,
    output logic      [2:0] enable
);

    typedef struct packed
    {
        logic [2:0] en;
    } sbs_en_state_t;

    sbs_en_state_t cur;
    sbs_en_state_t next_cur;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_en
            // set beats clear so an enable write is never lost
            always_comb
                next_cur.en[gi] = set_bits[gi] |
                                  (cur.en[gi] & ~clr_bits[gi]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur.en <= SBS_IRQ_EN_RESET;
        else
            cur <= next_cur;
    end

    assign enable = cur.en;

endmodule : sbs_irq_enable

// ===== sbs_top.sv
/*
 * sbs_top: buffer semaphore, shortcut, events and interrupt control of a
 * serial target peripheral, with an APB slave for the registers.
 * Assumes the transaction engine gives one-cycle pulses on pclk for its
 * lock request, transaction end and receive buffer end.
 */
`timescale 1ns/1ps

// Behaviour
// - shortcut bit makes transaction end re-request the lock; resets to zero
// - set register bit for end event enables it; read shows enable
// - clear register bit for end event disables it; read shows enable
// - receive-full event has own enable, set and clear, read back
// - lock-granted enable set by writing one; read shows state
// - lock-granted enable cleared by writing one; read shows state
// - owner field: 0 free, 1 processor, 2 engine, 3 engine with processor pending
// - owner field reads processor after reset
// - processor release frees lock so the engine can take it
// - receive-full event raised when engine reaches buffer end
module sbs_top
    import sbs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        spi_lock_request,
    input  wire logic        spi_transaction_end,
    input  wire logic        spi_rx_buffer_end,
    output logic             serial_target_owner,
    output logic             irq
);

    typedef struct packed
    {
        logic        short_en;
        logic        evt_end;
        logic        evt_rxfull;
        logic        evt_granted;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
        logic        spi_own;
    } sbs_top_state_t;

    sbs_top_state_t cur;
    sbs_top_state_t next_cur;

    sbs_owner_t owner;
    logic       granted;
    logic [2:0] irq_en;
    logic [2:0] en_set;
    logic [2:0] en_clr;
    logic       cpu_acquire;
    logic       cpu_release;
    logic       wr;
    logic       rd_setup;
    logic       wbit;

    // one wait-free access: writes land at the access edge
    assign wr       = psel && penable && pwrite && cur.ready;
    assign rd_setup = psel && !penable && !pwrite;
    assign wbit     = pwdata[SBS_BIT_TASK];

    assign cpu_acquire = (wr && paddr == SBS_ADDR_TASK_ACQUIRE && wbit)
                       || (cur.short_en && spi_transaction_end);
    assign cpu_release = wr && paddr == SBS_ADDR_TASK_RELEASE && wbit;

    assign en_set = (wr && paddr == SBS_ADDR_IRQ_SET)
                  ? {pwdata[SBS_BIT_GRANTED], pwdata[SBS_BIT_RXFULL],
                     pwdata[SBS_BIT_END]}
                  : 3'h0;
    assign en_clr = (wr && paddr == SBS_ADDR_IRQ_CLR)
                  ? {pwdata[SBS_BIT_GRANTED], pwdata[SBS_BIT_RXFULL],
                     pwdata[SBS_BIT_END]}
                  : 3'h0;

    sbs_lock_fsm u_lock
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .cpu_acquire (cpu_acquire),
        .cpu_release (cpu_release),
        .spi_request (spi_lock_request),
        .spi_done    (spi_transaction_end),
        .owner       (owner),
        .granted     (granted)
    );

    sbs_irq_enable u_en
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_bits (en_set),
        .clr_bits (en_clr),
        .enable   (irq_en)
    );

    always_comb
    begin
        next_cur        = cur;
        next_cur.ready  = 1'b0;
        next_cur.slverr = 1'b0;

        // ready answers the cycle after setup
        if (psel && !penable)
            next_cur.ready = 1'b1;

        if (wr && paddr == SBS_ADDR_SHORTCUT)
            next_cur.short_en = pwdata[SBS_BIT_SHORT];

        // event flags: software writes, hardware set wins
        if (wr && paddr == SBS_ADDR_EVT_END)
            next_cur.evt_end = pwdata[SBS_BIT_EVT];
        if (wr && paddr == SBS_ADDR_EVT_RXFULL)
            next_cur.evt_rxfull = pwdata[SBS_BIT_EVT];
        if (wr && paddr == SBS_ADDR_EVT_GRANTED)
            next_cur.evt_granted = pwdata[SBS_BIT_EVT];
        if (spi_transaction_end)
            next_cur.evt_end = 1'b1;
        if (spi_rx_buffer_end)
            next_cur.evt_rxfull = 1'b1;
        if (granted)
            next_cur.evt_granted = 1'b1;

        if (rd_setup)
        begin
            next_cur.rdata = SBS_ZERO_WORD;
            case (paddr)
                SBS_ADDR_EVT_END:
                    next_cur.rdata[SBS_BIT_EVT] = cur.evt_end;
                SBS_ADDR_EVT_RXFULL:
                    next_cur.rdata[SBS_BIT_EVT] = cur.evt_rxfull;
                SBS_ADDR_EVT_GRANTED:
                    next_cur.rdata[SBS_BIT_EVT] = cur.evt_granted;
                SBS_ADDR_SHORTCUT:
                    next_cur.rdata[SBS_BIT_SHORT] = cur.short_en;
                SBS_ADDR_IRQ_SET, SBS_ADDR_IRQ_CLR:
                begin
                    next_cur.rdata[SBS_BIT_END]     = irq_en[0];
                    next_cur.rdata[SBS_BIT_RXFULL]  = irq_en[1];
                    next_cur.rdata[SBS_BIT_GRANTED] = irq_en[2];
                end
                SBS_ADDR_OWNER:
                    next_cur.rdata[1:0] = owner;
                SBS_ADDR_TASK_ACQUIRE, SBS_ADDR_TASK_RELEASE:
                    next_cur.rdata = SBS_ZERO_WORD;
                default:
                    next_cur.slverr = 1'b1;
            endcase
        end
        else if (psel && !penable)
        begin
            case (paddr)
                SBS_ADDR_TASK_ACQUIRE, SBS_ADDR_TASK_RELEASE,
                SBS_ADDR_EVT_END, SBS_ADDR_EVT_RXFULL,
                SBS_ADDR_EVT_GRANTED, SBS_ADDR_SHORTCUT,
                SBS_ADDR_IRQ_SET, SBS_ADDR_IRQ_CLR, SBS_ADDR_OWNER:
                    next_cur.slverr = 1'b0;
                default:
                    next_cur.slverr = 1'b1;
            endcase
        end

        next_cur.irq = (next_cur.evt_end     && irq_en[0])
                    || (next_cur.evt_rxfull  && irq_en[1])
                    || (next_cur.evt_granted && irq_en[2]);
        next_cur.spi_own = (owner == SBS_OWN_SPI)
                        || (owner == SBS_OWN_SPI_PND);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur.short_en    <= 1'b0;
            cur.evt_end     <= 1'b0;
            cur.evt_rxfull  <= 1'b0;
            cur.evt_granted <= 1'b0;
            cur.rdata       <= SBS_ZERO_WORD;
            cur.ready       <= 1'b0;
            cur.slverr      <= 1'b0;
            cur.irq         <= 1'b0;
            cur.spi_own     <= 1'b0;
        end
        else
            cur <= next_cur;
    end

    assign prdata              = cur.rdata;
    assign pready              = cur.ready;
    assign pslverr             = cur.slverr;
    assign irq                 = cur.irq;
    assign serial_target_owner = cur.spi_own;

endmodule : sbs_top

// ===== sbs_top_props.sv
/* sbs_top_props: port checks of the buffer semaphore.
   Assumes wait-free APB answers and one-cycle engine pulses. */
`timescale 1ns/1ps
module sbs_top_props
    import sbs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        spi_lock_request,
    input wire logic        spi_transaction_end,
    input wire logic        spi_rx_buffer_end,
    input wire logic        serial_target_owner,
    input wire logic        irq
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero_data: assert property (pslverr && !pwrite |-> !prdata)
        else $error("refused read returned data");
    a_status_narrow: assert property
        (pready && !pwrite && paddr == SBS_ADDR_OWNER |-> !prdata[31:2])
        else $error("owner status upper bits set");
    a_owner_take_cause: assert property
        ($rose(serial_target_owner) |-> $past(spi_lock_request, 2))
        else $error("engine got lock without request");
    a_owner_drop_cause: assert property
        ($fell(serial_target_owner) |-> $past(spi_transaction_end, 2))
        else $error("engine lost lock without end");
    a_irq_drop_write: assert property
        ($fell(irq) |-> $past(psel && pwrite && pready)
            || $past(psel && pwrite && pready, 2))
        else $error("irq dropped without a write");
    a_reset_quiet: assert property
        ($rose(presetn) |-> !irq && !serial_target_owner && !pready)
        else $error("outputs active after reset");

    cover property ($rose(serial_target_owner));
    cover property ($fell(irq));
    cover property (pslverr);
endmodule : sbs_top_props

bind sbs_top sbs_top_props i_sbs_top_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_lock_request(spi_lock_request), .irq(irq),
    .spi_transaction_end(spi_transaction_end),
    .spi_rx_buffer_end(spi_rx_buffer_end),
    .serial_target_owner(serial_target_owner));

// ===== sbs_engine_model.sv
/* sbs_engine_model: transaction engine at the far side of the lock.
   Assumes go is a one-cycle pulse; hold is cycles spent owning. */
`timescale 1ns/1ps
module sbs_engine_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [3:0] hold,
    input  wire logic       serial_target_owner,
    output logic            spi_lock_request,
    output logic            spi_transaction_end,
    output logic            spi_rx_buffer_end
);
    logic       busy;
    logic [3:0] cnt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spi_lock_request    <= 1'b0;
            spi_transaction_end <= 1'b0;
            spi_rx_buffer_end   <= 1'b0;
            busy                <= 1'b0;
            cnt                 <= 4'h0;
        end
        else
        begin
            spi_lock_request    <= 1'b0;
            spi_transaction_end <= 1'b0;
            spi_rx_buffer_end   <= 1'b0;
            if (go)
            begin
                busy <= 1'b1;
                cnt  <= hold;
            end
            else if (busy && !serial_target_owner)
                spi_lock_request <= 1'b1;
            else if (busy && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (busy)
            begin
                spi_rx_buffer_end   <= 1'b1;
                spi_transaction_end <= 1'b1;
                busy                <= 1'b0;
            end
        end
    end
endmodule : sbs_engine_model

// ===== sbs_top_tb.sv
/* sbs_top_tb: register table, then lock, shortcut and reset tests.
   Assumes the engine model drives the far side of the lock. */
`timescale 1ns/1ps
module sbs_top_tb
    import sbs_pkg::*;
;
    typedef struct {logic [11:0] a; logic w; logic [31:0] d, x; logic e;}
        sbs_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        req, tend, rxend, sto, irq, go, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  hold;
    int          errors, compares;
    sbs_row_t    rows [16] = '{
        '{SBS_ADDR_OWNER, 1'h0, 32'h0, 32'h1, 1'h0},
        '{SBS_ADDR_SHORTCUT, 1'h0, 32'h0, 32'h0, 1'h0},
        '{SBS_ADDR_EVT_GRANTED, 1'h0, 32'h0, 32'h0, 1'h0},
        '{SBS_ADDR_IRQ_SET, 1'h1, 32'h0000_0412, 32'h0, 1'h0},
        '{SBS_ADDR_IRQ_SET, 1'h1, 32'h0, 32'h0, 1'h0},
        '{SBS_ADDR_IRQ_CLR, 1'h0, 32'h0, 32'h0000_0412, 1'h0},
        '{SBS_ADDR_IRQ_CLR, 1'h1, 32'h0, 32'h0, 1'h0},
        '{SBS_ADDR_IRQ_SET, 1'h0, 32'h0, 32'h0000_0412, 1'h0},
        '{SBS_ADDR_IRQ_CLR, 1'h1, 32'h0000_0012, 32'h0, 1'h0},
        '{SBS_ADDR_IRQ_SET, 1'h0, 32'h0, 32'h0000_0400, 1'h0},
        '{SBS_ADDR_IRQ_CLR, 1'h1, 32'h0000_0400, 32'h0, 1'h0},
        '{SBS_ADDR_IRQ_SET, 1'h0, 32'h0, 32'h0, 1'h0},
        '{12'h0FC, 1'h0, 32'h0, 32'h0, 1'h1},
        '{12'h0FC, 1'h1, 32'h1, 32'h0, 1'h1},
        '{SBS_ADDR_SHORTCUT, 1'h1, 32'h1, 32'h0, 1'h0},
        '{SBS_ADDR_SHORTCUT, 1'h0, 32'h0, 32'h1, 1'h0}};

    sbs_top i_sbs_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .spi_lock_request(req), .spi_transaction_end(tend),
        .spi_rx_buffer_end(rxend), .serial_target_owner(sto));
    sbs_engine_model i_sbs_engine_model (.pclk(pclk), .presetn(presetn),
        .go(go), .hold(hold), .serial_target_owner(sto),
        .spi_lock_request(req), .spi_transaction_end(tend),
        .spi_rx_buffer_end(rxend));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic stop_test();
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic check(input string n, input logic [31:0] x, g);
        compares++;
        if (g !== x)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
            check("pready", 32'h1, 32'h0);
        if (n == 20)
            stop_test();
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        check("read", x, rd);
    endtask : rdchk

    task automatic kick(input logic [3:0] h, input logic v);
        int n;
        go <= 1'b1;
        hold <= h;
        @(posedge pclk);
        go <= 1'b0;
        for (n = 0; n < 60 && sto !== v; n++)
            @(posedge pclk);
        check("engine owner", 32'(v), 32'(sto));
        if (sto !== v)
            stop_test();
    endtask : kick

    initial
    begin
        {presetn, psel, penable, pwrite, go, e} = 6'h00;
        {paddr, pwdata, hold, errors, compares} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                check("row data", rows[i].x, rd);
            check("row err", 32'(rows[i].e), 32'(e));
        end
        kick(4'hF, 1'b0);
        rdchk(SBS_ADDR_OWNER, 32'h1);
        apb(1'h1, SBS_ADDR_IRQ_SET, 32'h0000_0412);
        apb(1'h1, SBS_ADDR_TASK_RELEASE, 32'h1);
        repeat (3) @(posedge pclk);
        rdchk(SBS_ADDR_OWNER, 32'h2);
        apb(1'h1, SBS_ADDR_TASK_ACQUIRE, 32'h1);
        rdchk(SBS_ADDR_OWNER, 32'h3);
        kick(4'h0, 1'b0);
        check("irq", 32'h1, 32'(irq));
        rdchk(SBS_ADDR_OWNER, 32'h1);
        rdchk(SBS_ADDR_EVT_RXFULL, 32'h1);
        apb(1'h1, SBS_ADDR_EVT_RXFULL, 32'h0);
        apb(1'h1, SBS_ADDR_EVT_END, 32'h0);
        check("irq", 32'h1, 32'(irq));
        apb(1'h1, SBS_ADDR_EVT_GRANTED, 32'h0);
        check("irq", 32'h0, 32'(irq));
        apb(1'h1, SBS_ADDR_SHORTCUT, 32'h1);
        apb(1'h1, SBS_ADDR_TASK_RELEASE, 32'h1);
        kick(4'h2, 1'b1);
        kick(4'h2, 1'b0);
        rdchk(SBS_ADDR_OWNER, 32'h1);
        rdchk(SBS_ADDR_EVT_GRANTED, 32'h1);
        apb(1'h1, SBS_ADDR_SHORTCUT, 32'h0);
        apb(1'h1, SBS_ADDR_TASK_RELEASE, 32'h1);
        kick(4'h2, 1'b1);
        kick(4'h2, 1'b0);
        rdchk(SBS_ADDR_OWNER, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(SBS_ADDR_OWNER, 32'h1);
        rdchk(SBS_ADDR_IRQ_SET, 32'h0);
        stop_test();
    end
endmodule : sbs_top_tb
